// File: hdl/apsb_analog_pin_router.sv
// Analog pin select bank: two select registers steering the analog pin switches.
// Assumes a synchronous special-function register bus with page, address and strobes,
// and analog switch drivers that take the route outputs as steady levels.
`timescale 1ns/10ps
`include "apsb_consts.svh"
module apsb_analog_pin_router #(
    // Pins per port; the byte-wide registers serve no other count
    parameter int PinCount = `APSB_PINS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register bus
    input wire logic [7:0] sfrPage,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWr,
    input wire logic sfrRd,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    output logic sfrHit,
    // Routing to the analog switches
    output logic [7:0] port0Route,
    output logic [7:0] port1Route,
    output logic anyPinRouted
);
    // Refuse a pin count that the byte-wide registers and ports cannot carry
    // A wider bank needs wider bus ports and registers, not just this number
    if (PinCount != `APSB_PINS) begin : g_badPinCount
        $error("PinCount must match the eight-bit select registers");
    end

    // Whole state of the bank, plus its next value
    apsb_pkg::apsb_state_t state_q;
    apsb_pkg::apsb_state_t state_d;
    // Register selects for this cycle's bus request
    logic hitP0;
    logic hitP1;

    // True when the bus names the given register on this block's page
    function automatic logic regSelect(input logic [7:0] page, input logic [7:0] addr,
        input logic [7:0] target);
        regSelect = (page == `APSB_PAGE) && (addr == target);
    endfunction

    // Decode; other pages and addresses belong to other blocks
    // One shared function, so the write and read paths can never disagree
    assign hitP0 = regSelect(sfrPage, sfrAddr, `APSB_ADDR_P0);
    assign hitP1 = regSelect(sfrPage, sfrAddr, `APSB_ADDR_P1);
    assign sfrHit = hitP0 || hitP1;

    // A hit must sit on this block's page
    property p_hitPage;
        @(posedge mclk) disable iff (!rst_n)
        sfrHit |-> (sfrPage == `APSB_PAGE);
    endproperty
    a_hitPage: assert property (p_hitPage) else $error("hit on a foreign page");

    // Only the two mapped addresses may hit
    property p_hitAddr;
        @(posedge mclk) disable iff (!rst_n)
        sfrHit |-> (sfrAddr == `APSB_ADDR_P0 || sfrAddr == `APSB_ADDR_P1);
    endproperty
    a_hitAddr: assert property (p_hitAddr) else $error("hit on an unmapped address");

    // A mapped address on this page must hit, or its writes would be lost
    property p_hitTaken;
        @(posedge mclk) disable iff (!rst_n)
        (sfrPage == `APSB_PAGE && (sfrAddr == `APSB_ADDR_P0 || sfrAddr == `APSB_ADDR_P1))
            |-> sfrHit;
    endproperty
    a_hitTaken: assert property (p_hitTaken) else $error("register not decoded");

    // Next state: a write replaces the whole register, the other one is left alone
    // Both strobes in one cycle are fine: the read sees the old value
    always_comb begin
        state_d = state_q;
        if (sfrWr && hitP0) begin
            state_d.port0Sel = sfrWdata;
        end
        if (sfrWr && hitP1) begin
            state_d.port1Sel = sfrWdata;
        end
    end

    // A port 0 write reaches its routes on the next edge
    property p_wr0;
        @(posedge mclk) disable iff (!rst_n)
        (sfrWr && hitP0) |=> (port0Route == $past(sfrWdata));
    endproperty
    a_wr0: assert property (p_wr0) else $error("port0 write not applied");

    // A port 1 write reaches its routes on the next edge
    property p_wr1;
        @(posedge mclk) disable iff (!rst_n)
        (sfrWr && hitP1) |=> (port1Route == $past(sfrWdata));
    endproperty
    a_wr1: assert property (p_wr1) else $error("port1 write not applied");

    // A port 0 write leaves port 1 routing untouched
    property p_wr0Only;
        @(posedge mclk) disable iff (!rst_n)
        (sfrWr && hitP0) |=> $stable(port1Route);
    endproperty
    a_wr0Only: assert property (p_wr0Only) else $error("port1 disturbed");

    // A port 1 write leaves port 0 routing untouched
    property p_wr1Only;
        @(posedge mclk) disable iff (!rst_n)
        (sfrWr && hitP1) |=> $stable(port0Route);
    endproperty
    a_wr1Only: assert property (p_wr1Only) else $error("port0 disturbed");

    // Without a write the switches must hold still
    // A stray change would move charge into a pin under measurement
    property p_hold;
        @(posedge mclk) disable iff (!rst_n)
        !(sfrWr && sfrHit) |=> $stable(port0Route) && $stable(port1Route);
    endproperty
    a_hold: assert property (p_hold) else $error("routing changed without write");

    // Writes to other pages or addresses are refused
    property p_wrMiss;
        @(posedge mclk) disable iff (!rst_n)
        (sfrWr && !sfrHit) |=> $stable(port0Route) && $stable(port1Route);
    endproperty
    a_wrMiss: assert property (p_wrMiss) else $error("foreign write applied");

    // A full port 0 group select must reach every port 0 pin at once
    // The sensing unit binds or scans whatever is presented to it
    property p_all;
        @(posedge mclk) disable iff (!rst_n)
        (sfrWr && hitP0 && sfrWdata == 8'hFF) |=> (port0Route == 8'hFF);
    endproperty
    a_all: assert property (p_all) else $error("group select lost");

    // Registers clear to all-disconnected
    // The reset branch loads constants only, so release timing cannot leak data in
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= {`APSB_RESET_VAL, `APSB_RESET_VAL};
        end else begin
            state_q <= state_d;
        end
    end

    // While reset is held, every switch is open and reads give zero
    // Two low samples, so the check never sees the flops before reset first reaches them
    property p_rstClear;
        @(posedge mclk)
        !rst_n ##1 !rst_n |-> (port0Route == `APSB_RESET_VAL &&
            port1Route == `APSB_RESET_VAL && !anyPinRouted && sfrRdata == 8'h00);
    endproperty
    a_rstClear: assert property (p_rstClear) else $error("reset left pins routed");

    // Routing straight from the flops, so switches never glitch on bus activity
    // Every selected pin is presented at once; the front end picks how to use them
    assign port0Route = state_q.port0Sel;
    assign port1Route = state_q.port1Sel;
    // Lets the converter side see that pins are routed; policing is software's job
    assign anyPinRouted = |{state_q.port0Sel, state_q.port1Sel};

    // The routed flag follows the routes exactly
    property p_anyFlag;
        @(posedge mclk) disable iff (!rst_n)
        anyPinRouted == ((port0Route != 8'h00) || (port1Route != 8'h00));
    endproperty
    a_anyFlag: assert property (p_anyFlag) else $error("routed flag wrong");

    // Read mux; unmapped addresses read zero
    // Zero outside a read keeps the shared read bus quiet for other blocks
    always_comb begin
        sfrRdata = 8'h00;
        if (sfrRd && hitP0) begin
            sfrRdata = state_q.port0Sel;
        end else if (sfrRd && hitP1) begin
            sfrRdata = state_q.port1Sel;
        end
    end

    // A port 0 read shows the register in the same cycle
    property p_rd0;
        @(posedge mclk) disable iff (!rst_n)
        (sfrRd && hitP0) |-> (sfrRdata == port0Route);
    endproperty
    a_rd0: assert property (p_rd0) else $error("port0 readback mismatch");

    // A port 1 read shows the register in the same cycle
    property p_rd;
        @(posedge mclk) disable iff (!rst_n)
        (sfrRd && hitP1) |-> (sfrRdata == port1Route);
    endproperty
    a_rd: assert property (p_rd) else $error("readback mismatch");

    // No read, or a foreign address, leaves the read data at zero
    property p_rdIdle;
        @(posedge mclk) disable iff (!rst_n)
        !(sfrRd && sfrHit) |-> (sfrRdata == 8'h00);
    endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("read data not quiet");

    // Reading port 0 right after writing it returns what was written
    property p_rdBack0;
        @(posedge mclk) disable iff (!rst_n)
        (sfrWr && hitP0) ##1 (sfrRd && hitP0)
            |-> (sfrRdata == $past(sfrWdata));
    endproperty
    a_rdBack0: assert property (p_rdBack0) else $error("port0 write not read back");

    // Reading port 1 right after writing it returns what was written
    property p_rdBack1;
        @(posedge mclk) disable iff (!rst_n)
        (sfrWr && hitP1) ##1 (sfrRd && hitP1)
            |-> (sfrRdata == $past(sfrWdata));
    endproperty
    a_rdBack1: assert property (p_rdBack1) else $error("port1 write not read back");

    // Main scenarios: both writes, a live readback, a full group, read with write
    // Coverage only; nothing here changes behaviour
    c_w0: cover property (@(posedge mclk) sfrWr && hitP0);
    c_w1: cover property (@(posedge mclk) sfrWr && hitP1);
    c_rd: cover property (@(posedge mclk) sfrRd && hitP0 && sfrRdata != 8'h00);
    c_group: cover property (@(posedge mclk) port0Route == 8'hFF);
    c_rdWr: cover property (@(posedge mclk) sfrRd && sfrWr && sfrHit);
endmodule

// File: hdl/apsb_consts.svh
// Constants for the analog pin select bank: register map, reset values, widths.
// Assumes the special-function register bus decodes page and address as given here.
// What this block does
// - Port 0 select bit n at 1 routes port 0 pin n to the analog multiplexer, at 0 leaves it open.
// - Port 1 select bit n at 1 routes port 1 pin n to the analog multiplexer, at 0 leaves it open.
// - Both 8-bit read-write select registers sit on register page 0x0 at 0x9A and 0x9B, reset 0.
// - For capacitive sensing every selected pin is presented to the sensing unit.
`ifndef APSB_CONSTS_SVH
`define APSB_CONSTS_SVH
`define APSB_PAGE 8'h00
`define APSB_ADDR_P0 8'h9A
`define APSB_ADDR_P1 8'h9B
`define APSB_RESET_VAL 8'h00
`define APSB_PINS 8
`endif

// File: hdl/apsb_pkg.sv
// Types for the analog pin select bank.
// Assumes apsb_consts.svh for sizes.
`include "apsb_consts.svh"
package apsb_pkg;
    // Whole state of the bank
    typedef struct packed {
        logic [`APSB_PINS-1:0] port0Sel;
        logic [`APSB_PINS-1:0] port1Sel;
    } apsb_state_t;
endpackage

// File: verif/apsb_front_end.sv
// Stand-in for the sense and converter front ends.
// Assumes the bank's route outputs.
`timescale 1ns/10ps
module apsb_front_end (
    // Routes in
    input wire logic [7:0] p0,
    input wire logic [7:0] p1,
    // Pins seen
    output logic [4:0] nPins
);
    // Counts every pin presented to it
    always_comb nPins = 5'($countones({p0, p1}));
endmodule

// File: verif/apsb_analog_pin_router_tb_top.sv
// Self-checking bench for the pin select bank.
// Assumes the constants header on the include path and the front-end model beside it.
`timescale 1ns/10ps
`include "apsb_consts.svh"
module apsb_analog_pin_router_tb_top;
    logic mclk = 0, rst_n = 0, sfrWr = 0, sfrRd = 0, sfrHit, anyPinRouted;
    logic [7:0] sfrPage = '0, sfrAddr = '0, sfrWdata = '0, sfrRdata;
    logic [7:0] port0Route, port1Route, m0 = '0, m1 = '0;
    logic [4:0] nPins;
    logic [30:0] observed;
    logic [30:0] q[$];
    int nMismatch = 0, nCompared = 0;
    apsb_analog_pin_router u_dut (.mclk, .rst_n, .sfrPage, .sfrAddr, .sfrWr, .sfrRd,
        .sfrWdata, .sfrRdata, .sfrHit, .port0Route, .port1Route, .anyPinRouted);
    apsb_front_end u_fe (.p0(port0Route), .p1(port1Route), .nPins);
    // Everything a read shows: decode, pins seen, flag, data and both routes
    assign observed = {sfrHit, nPins, anyPinRouted, sfrRdata, port0Route, port1Route};
    initial forever #5 mclk = ~mclk;
    task automatic check(logic [30:0] seen, logic [30:0] exp);
        nCompared++;
        if (seen !== exp) begin
            nMismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tallyAndFinish;
        $display("compared=%0d mismatches=%0d", nCompared, nMismatch);
        if (nMismatch == 0 && nCompared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // One bus cycle; a read notes what it must return, old value if written too
    task automatic acc(bit rd, bit wr, logic [7:0] pg, logic [7:0] ad, logic [7:0] d);
        logic hit;
        @(posedge mclk);
        hit = pg == `APSB_PAGE && (ad == `APSB_ADDR_P0 || ad == `APSB_ADDR_P1);
        sfrRd <= rd;
        sfrWr <= wr;
        sfrPage <= pg;
        sfrAddr <= ad;
        sfrWdata <= d;
        if (rd) q.push_back({hit, 5'($countones({m0, m1})), |{m0, m1},
            hit ? (ad == `APSB_ADDR_P1 ? m1 : m0) : 8'h00, m0, m1});
        if (wr && hit && ad == `APSB_ADDR_P0) m0 = d;
        if (wr && hit && ad == `APSB_ADDR_P1) m1 = d;
    endtask
    // Reset in mid-run: strobes drop on the same edge that asserts reset, then both registers must clear
    task automatic pulseReset;
        @(posedge mclk);
        sfrRd <= 0;
        sfrWr <= 0;
        rst_n <= 0;
        m0 = 8'h00;
        m1 = 8'h00;
        repeat (2) @(posedge mclk);
        rst_n <= 1;
    endtask
    // Watcher: read data and routes are settled by the falling edge; no note is a miss
    always @(negedge mclk) begin
        if (sfrRd && q.size() == 0) begin
            check(31'h0, 31'h1);
        end else if (sfrRd) begin
            check(observed, q.pop_front());
        end
    end
    initial begin
        void'($urandom(21));
        repeat (10) @(posedge mclk);
        rst_n <= 1;
        acc(1, 0, `APSB_PAGE, `APSB_ADDR_P1, 8'h00);
        for (int i = 0; i < 8; i++) begin
            acc(1, 1, `APSB_PAGE, `APSB_ADDR_P0, 8'($urandom));
            acc(1, 1, `APSB_PAGE, `APSB_ADDR_P1, 8'h01 << i);
        end
        pulseReset();
        acc(1, 0, `APSB_PAGE, `APSB_ADDR_P0, 8'h00);
        acc(1, 1, `APSB_PAGE, `APSB_ADDR_P0, 8'hFF);
        acc(1, 0, `APSB_PAGE, `APSB_ADDR_P0, 8'h00);
        acc(1, 1, 8'h01, `APSB_ADDR_P0, 8'h00);
        acc(1, 1, `APSB_PAGE, 8'h9C, 8'hFF);
        acc(0, 1, `APSB_PAGE, `APSB_ADDR_P0, 8'h00);
        acc(1, 1, `APSB_PAGE, `APSB_ADDR_P1, 8'h01 << ($urandom % 8));
        acc(1, 0, `APSB_PAGE, `APSB_ADDR_P1, 8'h00);
        acc(1, 1, `APSB_PAGE, `APSB_ADDR_P0, 8'h00);
        acc(1, 1, `APSB_PAGE, `APSB_ADDR_P1, 8'h00);
        acc(1, 0, `APSB_PAGE, `APSB_ADDR_P0, 8'h00);
        acc(0, 0, 8'h00, 8'h00, 8'h00);
        @(posedge mclk);
        tallyAndFinish();
    end
endmodule
